// File: rtl/pram_consts.svh
// constants for the phase rotation alarm monitor
// assumes a 100 MHz clock; included by the package and the monitor
`ifndef PRAM_CONSTS_SVH
`define PRAM_CONSTS_SVH
`define PRAM_CLK_HZ        100000000
`define PRAM_DELAY_MS      2000
`define PRAM_DELAY_CYC     ((`PRAM_CLK_HZ / 1000) * `PRAM_DELAY_MS)
`define PRAM_RESP_MAX_MS   3000
`define PRAM_HALF_RATED_PC 50
`define PRAM_FLAG_COUNT    32
`define PRAM_SRC_ALWAYS    2'h0
`define PRAM_SRC_LOCK      2'h1
`define PRAM_SRC_FLAG      2'h2
`define PRAM_CLASS_DEFAULT 3'h5
`define PRAM_MODE_3PH4W    2'h0
`define PRAM_MODE_3PH3W    2'h1
`define PRAM_MODE_1PH2W    2'h2
`endif

// File: rtl/pram_pkg.sv
// types for the phase rotation alarm monitor
// assumes pram_consts.svh for the numeric values
`include "pram_consts.svh"
package pram_pkg;
   typedef enum logic [1:0] {
      pram_rotation_forward = 2'h0,
      pram_rotation_reverse = 2'h1,
      pram_rotation_unknown = 2'h2
   } pram_rot_t;
   typedef enum logic [6:0] {
      pram_class_a = 7'h01, pram_class_b = 7'h02, pram_class_c = 7'h04,
      pram_class_d = 7'h08, pram_class_e = 7'h10, pram_class_f = 7'h20,
      pram_class_control = 7'h40
   } pram_class_t;
   typedef enum logic [2:0] {
      pram_st_idle    = 3'h1,
      pram_st_qualify = 3'h2,
      pram_st_alarm   = 3'h4
   } pram_state_t;
endpackage

// File: rtl/pram_qual_timer.sv
// qualification timer: counts an uninterrupted condition to a terminal count
// assumes a synchronous active high reset and one clock
module pram_qual_timer #(
   parameter int unsigned DELAY_CYC = 200000000
) (
   // clock, reset and enable
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic enable_in,
   // condition
   input  wire logic cond_in,
   output logic      done_out
);
   localparam int W = $clog2(DELAY_CYC + 1);
   typedef struct packed {
      logic [W-1:0] count;
      logic         done;
   } pram_tmr_t;
   pram_tmr_t s, next_s;

   always_comb begin
      next_s = s;
      if (!cond_in) begin
         next_s.count = '0;
         next_s.done  = 1'b0;
      end else if (s.count < W'(DELAY_CYC - 1)) begin
         next_s.count = s.count + W'(1);
      end else begin
         next_s.done = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s <= '0;
      end else if (enable_in) begin
         s <= next_s;
      end
   end

   assign done_out = s.done & cond_in;
endmodule

// File: rtl/pram_monitor.sv
// phase rotation alarm monitor: mismatch qualify, class, acknowledge
// assumes inputs synchronous to clk_in, rotation from a measurement front end
`include "pram_consts.svh"
module pram_monitor
   import pram_pkg::*;
#(
   parameter int unsigned DELAY_CYC  = `PRAM_DELAY_CYC,
   parameter int unsigned FLAG_COUNT = `PRAM_FLAG_COUNT
) (
   // clock, reset, enable
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  clk_en_in,
   // configuration
   input  wire logic                  monitor_off_in,
   input  wire logic                  expect_reverse_in,
   input  wire logic [2:0]            alarm_class_in,
   input  wire logic                  self_ack_in,
   input  wire logic [1:0]            enable_source_in,
   input  wire logic [4:0]            user_flag_select_in,
   input  wire logic [1:0]            meas_mode_in,
   input  wire logic                  single_phase_reverse_in,
   // measurement front end
   input  wire pram_pkg::pram_rot_t   measured_rotation_in,
   input  wire logic                  voltage_above_half_in,
   // gating and acknowledge
   input  wire logic                  lock_monitoring_in,
   input  wire logic [FLAG_COUNT-1:0] user_flags_in,
   input  wire logic                  ext_ack_in,
   // alarm
   output logic                       alarm_out,
   output logic                       mismatch_msg_out,
   output logic                       cmd_var_out,
   output pram_pkg::pram_class_t      alarm_class_out,
   output logic                       mismatch_out
);
   function automatic pram_class_t class_decode(input logic [2:0] code);
      case (code)
         3'h0:    class_decode = pram_class_a;
         3'h1:    class_decode = pram_class_b;
         3'h2:    class_decode = pram_class_c;
         3'h3:    class_decode = pram_class_d;
         3'h4:    class_decode = pram_class_e;
         3'h5:    class_decode = pram_class_f;
         default: class_decode = pram_class_control;
      endcase
   endfunction

   typedef struct packed {
      pram_state_t state;
      logic        mismatch;
      pram_class_t cls;
   } pram_st_t;
   pram_st_t s, next_s;

   logic      enabled;
   logic      valid_meas;
   pram_rot_t actual_rot;
   pram_rot_t expect_rot;
   logic      fault;
   logic      qual_cond;
   logic      qualified;

   always_comb begin
      // single-phase uses configured rotation, three-phase needs voltage
      if (meas_mode_in == `PRAM_MODE_1PH2W) begin
         actual_rot = single_phase_reverse_in ? pram_rotation_reverse
                                              : pram_rotation_forward;
         valid_meas = 1'b1;
      end else begin
         actual_rot = measured_rotation_in;
         valid_meas = voltage_above_half_in
                      && measured_rotation_in != pram_rotation_unknown;
      end
      expect_rot = expect_reverse_in ? pram_rotation_reverse
                                     : pram_rotation_forward;
      if (enable_source_in == `PRAM_SRC_LOCK) begin
         enabled = !lock_monitoring_in;
      end else if (enable_source_in == `PRAM_SRC_FLAG) begin
         enabled = user_flags_in[user_flag_select_in];
      end else begin
         enabled = 1'b1;
      end
      enabled   = enabled && !monitor_off_in;
      fault     = valid_meas && (actual_rot != expect_rot);
      qual_cond = enabled && fault;
   end

   pram_qual_timer #(
      .DELAY_CYC (DELAY_CYC)
   ) u_timer (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .enable_in (clk_en_in),
      .cond_in   (qual_cond),
      .done_out  (qualified)
   );

   always_comb begin
      next_s          = s;
      next_s.mismatch = qual_cond;
      case (s.state)
         pram_st_idle: begin
            if (qual_cond) begin
               next_s.state = pram_st_qualify;
            end
         end
         pram_st_qualify: begin
            if (!qual_cond) begin
               next_s.state = pram_st_idle;
            end else if (qualified) begin
               next_s.state = pram_st_alarm;
               next_s.cls   = class_decode(alarm_class_in);
            end
         end
         pram_st_alarm: begin
            if (!qual_cond && self_ack_in) begin
               next_s.state = pram_st_idle;
            end else if (!qual_cond && ext_ack_in) begin
               next_s.state = pram_st_idle;
            end
         end
         default: next_s.state = pram_st_idle;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s.state    <= pram_st_idle;
         s.mismatch <= 1'b0;
         s.cls      <= pram_class_f;
      end else if (clk_en_in) begin
         s <= next_s;
      end
   end

   assign alarm_out        = (s.state == pram_st_alarm);
   assign mismatch_msg_out = alarm_out;
   assign cmd_var_out      = alarm_out;
   assign alarm_class_out  = s.cls;
   assign mismatch_out     = s.mismatch;

   // checks
   a_off_no_alarm: assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && monitor_off_in && !alarm_out |=> !(alarm_out && !$past(alarm_out)))
      else $error("alarm rose while monitoring off");
   a_rise_needs_cond: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(alarm_out) |-> $past(qualified) && $past(qual_cond))
      else $error("alarm rose without qualified mismatch");
   a_fwd_expect: assert property (@(posedge clk_in) disable iff (reset_in)
      meas_mode_in != `PRAM_MODE_1PH2W && !expect_reverse_in
         && measured_rotation_in == pram_rotation_forward |-> !fault)
      else $error("forward rotation flagged as fault");
   a_rev_expect: assert property (@(posedge clk_in) disable iff (reset_in)
      meas_mode_in != `PRAM_MODE_1PH2W && expect_reverse_in && voltage_above_half_in
         && measured_rotation_in == pram_rotation_forward |-> fault)
      else $error("forward rotation not flagged while reverse expected");
   a_class_held: assert property (@(posedge clk_in) disable iff (reset_in)
      alarm_out && $past(alarm_out) |-> $stable(alarm_class_out))
      else $error("class changed during alarm");
   a_self_clear: assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && alarm_out && self_ack_in && !qual_cond |=> !alarm_out)
      else $error("self acknowledge did not clear");
   a_latch_hold: assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && alarm_out && !self_ack_in && !ext_ack_in |=> alarm_out)
      else $error("alarm dropped without acknowledge");
   a_lock_gate: assert property (@(posedge clk_in) disable iff (reset_in)
      enable_source_in == `PRAM_SRC_LOCK && lock_monitoring_in |-> !qual_cond)
      else $error("evaluating while locked");
   a_flag_gate: assert property (@(posedge clk_in) disable iff (reset_in)
      enable_source_in == `PRAM_SRC_FLAG && !user_flags_in[user_flag_select_in] |-> !qual_cond)
      else $error("evaluating with flag false");
   a_cmd_var: assert property (@(posedge clk_in) disable iff (reset_in)
      cmd_var_out == alarm_out && mismatch_msg_out == alarm_out)
      else $error("command variable not tied to alarm");
   a_low_volt: assert property (@(posedge clk_in) disable iff (reset_in)
      meas_mode_in != `PRAM_MODE_1PH2W && !voltage_above_half_in |-> !fault)
      else $error("fault at low voltage");
   a_restart: assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && !qual_cond |=> !qualified)
      else $error("timer not restarted");
   a_class_capture: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(alarm_out) |-> alarm_class_out == class_decode($past(alarm_class_in)))
      else $error("class not captured at alarm rise");
   a_ack_refused: assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && alarm_out && qual_cond |=> alarm_out)
      else $error("alarm cleared while mismatch present");
   a_off_gate: assert property (@(posedge clk_in) disable iff (reset_in)
      monitor_off_in |-> !qual_cond)
      else $error("evaluating while monitoring off");
   a_mismatch_reg: assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in |=> mismatch_out == $past(qual_cond))
      else $error("mismatch output not registered condition");
   a_always_gate: assert property (@(posedge clk_in) disable iff (reset_in)
      enable_source_in != `PRAM_SRC_LOCK && enable_source_in != `PRAM_SRC_FLAG
         && !monitor_off_in |-> enabled)
      else $error("always source gated");
   a_qualify_first: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(alarm_out) |-> $past(s.state) == pram_st_qualify)
      else $error("alarm rose without qualification");
   a_single_phase: assert property (@(posedge clk_in) disable iff (reset_in)
      meas_mode_in == `PRAM_MODE_1PH2W
         |-> fault == (single_phase_reverse_in != expect_reverse_in))
      else $error("single phase rotation not taken from setting");

   c_alarm: cover property (@(posedge clk_in) $rose(alarm_out));
   c_flag: cover property (@(posedge clk_in) enable_source_in == `PRAM_SRC_FLAG && alarm_out);
   c_self: cover property (@(posedge clk_in) $fell(alarm_out) && self_ack_in);
   c_ack: cover property (@(posedge clk_in) $fell(alarm_out) && !self_ack_in);
   c_abort: cover property (@(posedge clk_in) s.state == pram_st_qualify && !qual_cond);
endmodule

// File: tb/pram_front_model.sv
// front end model: turns a phase sequence and a voltage level into rotation inputs
// assumes the bench sets the sequence code and the level in percent of rated
module pram_front_model
   import pram_pkg::*;
(
   // sequence and level
   input  wire logic [1:0]     seq_in,
   input  wire logic [7:0]     level_pc_in,
   // to the monitor
   output pram_pkg::pram_rot_t rot_out,
   output logic                above_half_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      case (seq_in)
         2'h0:    rot_out = pram_rotation_forward;
         2'h1:    rot_out = pram_rotation_reverse;
         default: rot_out = pram_rotation_unknown;
      endcase
      above_half_out = (level_pc_in > 8'h32);
   end
endmodule

// File: tb/tb_phase_rotation_alarm_monitor.sv
// bench for the phase rotation alarm monitor: directed and random trials
// assumes the package, the monitor and the front end model are compiled first
module tb_phase_rotation_alarm_monitor;
   timeunit 1ns;
   timeprecision 1ns;
   import pram_pkg::*;
   localparam int unsigned D = 20;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        off, rev, sack, ack, lock, sprev, above, alarm, msg, cmdv, mis;
   logic        en = 1'b1;
   logic [2:0]  cls;
   logic [1:0]  src, mode, seq;
   logic [4:0]  fsel;
   logic [31:0] flags;
   logic [7:0]  lvl;
   pram_rot_t   rot;
   pram_class_t cls_out;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;
   int          seed = 32'h2E20DF4F;
   pram_front_model pram_front_model_inst (.seq_in(seq), .level_pc_in(lvl), .rot_out(rot),
      .above_half_out(above));
   pram_monitor #(.DELAY_CYC(D), .FLAG_COUNT(32)) pram_monitor_inst (.clk_in(clk_in),
      .reset_in(reset_in), .clk_en_in(en), .monitor_off_in(off), .expect_reverse_in(rev),
      .alarm_class_in(cls), .self_ack_in(sack), .enable_source_in(src),
      .user_flag_select_in(fsel), .meas_mode_in(mode), .single_phase_reverse_in(sprev),
      .measured_rotation_in(rot), .voltage_above_half_in(above), .lock_monitoring_in(lock),
      .user_flags_in(flags), .ext_ack_in(ack), .alarm_out(alarm), .mismatch_msg_out(msg),
      .cmd_var_out(cmdv), .alarm_class_out(cls_out), .mismatch_out(mis));
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // reference: would a steady fault raise the alarm with the present settings
   function automatic bit model_alarm();
      bit gate, valid, meas_rev;
      gate = (src == 2'h1) ? !lock : (src == 2'h2) ? flags[fsel] : 1'b1;
      valid = (mode == 2'h2) || (lvl > 8'h32 && seq != 2'h2);
      meas_rev = (mode == 2'h2) ? sprev : (seq == 2'h1);
      return !off && gate && valid && (meas_rev != rev);
   endfunction
   task automatic trial(input string name);
      bit         want;
      logic [6:0] wcls;
      want = model_alarm();
      wcls = (cls < 3'h6) ? (7'h01 << cls) : 7'h40;
      reset_in = 1'b1;
      cyc(2);
      chk({6'h00, alarm}, 7'h00);
      chk(cls_out, 7'h20);
      reset_in = 1'b0;
      cyc(D - 2);
      chk({6'h00, alarm}, 7'h00);
      cyc(6);
      chk({4'h0, alarm, msg, cmdv}, want ? 7'h07 : 7'h00);
      chk({6'h00, mis}, {6'h00, want});
      if (want) chk(cls_out, wcls);
      $display("test %s done", name);
   endtask
   task automatic clear_check(input bit self);
      sack = self;
      ack = 1'b1;
      cyc(3);
      chk({6'h00, alarm}, 7'h01);
      ack = 1'b0;
      seq = {1'b0, rev};
      cyc(3);
      chk({6'h00, alarm}, {6'h00, ~self});
      ack = 1'b1;
      cyc(2);
      chk({6'h00, alarm}, 7'h00);
      ack = 1'b0;
      $display("test clear done");
   endtask
   initial begin
      {off, rev, sack, ack, lock, sprev} = 6'h00;
      cls = 3'h5;
      {src, mode, seq} = 6'h01;
      fsel = 5'h00;
      flags = 32'h0;
      lvl = 8'h64;
      cyc(8);
      for (int k = 0; k < 8; k++) begin
         cls = k[2:0];
         rev = k[0];
         seq = {1'b0, ~k[0]};
         trial("class");
         clear_check(k[1]);
      end
      seq = 2'h0;
      rev = 1'b0;
      trial("match");
      seq = 2'h1;
      off = 1'b1;
      trial("off");
      off = 1'b0;
      lock = 1'b1;
      trial("always");
      src = 2'h1;
      trial("lock on");
      lock = 1'b0;
      trial("lock off");
      src = 2'h2;
      for (int k = 0; k < 8; k++) begin
         flags = $random(seed);
         fsel = 5'($random(seed));
         cls = 3'($random(seed));
         trial("flag");
      end
      src = 2'h0;
      lvl = 8'h32;
      trial("low volt");
      mode = 2'h1;
      lvl = 8'h33;
      trial("three wire");
      mode = 2'h2;
      lvl = 8'h00;
      seq = 2'h0;
      sprev = 1'b1;
      trial("single phase");
      mode = 2'h0;
      lvl = 8'h64;
      seq = 2'h2;
      trial("unknown");
      seq = 2'h1;
      reset_in = 1'b1;
      cyc(2);
      reset_in = 1'b0;
      cyc(D - 3);
      seq = 2'h0;
      cyc(1);
      seq = 2'h1;
      cyc(D - 3);
      chk({6'h00, alarm}, 7'h00);
      cyc(8);
      chk({6'h00, alarm}, 7'h01);
      $display("test restart done");
      reset_in = 1'b1;
      cyc(2);
      reset_in = 1'b0;
      cyc(5);
      en = 1'b0;
      cyc(10);
      en = 1'b1;
      cyc(D - 6);
      chk({6'h00, alarm}, 7'h00);
      cyc(4);
      chk({6'h00, alarm}, 7'h01);
      $display("test freeze done");
      results();
   end
endmodule
